/* File: rtl/branch_and_subroutine_flow_unit.sv */
`timescale 1ns/10ps
// Summary of operation
// R1: Taken short branch adds sign-extended 8-bit displacement to PC.
// R2: Short displacement spans -128..127 from address after the instruction.
// R3: Taken long branch adds signed 16-bit displacement to PC.
// R4: Long displacement spans -32768..32767, reaching the whole 64K map.
// R5: Always-form always branches, never-form never; both use displacement.
// R6: Simple branches test one flag: C, Z, N or V, set or clear.
// R7: Unsigned: higher C|Z=0, same-or-higher C=0, lower C=1, lower-same C|Z=1.
// R8: Signed: GE N^V=0, LT N^V=1, GT Z|(N^V)=0, LE Z|(N^V)=1.
// R9: Long branches test same conditions; long lower tests carry set.
// R10: Bit branches read byte, mask it; all-ones or all-zeros selects taken.
// R11: Bit branches use signed 8-bit displacement after the instruction.
// R12: Loop counter is A, B, D, X, Y or SP; dec, inc or test forms.
// R13: Loop branches use signed 9-bit displacement, -256..255.
// R14: Dec and inc forms update counter first, then test zero or nonzero.
// R15: Test-only forms leave counter alone, branch on zero or nonzero.
// R16: Jump loads PC with a 16-bit absolute or computed target.
// R17: Calls lower SP by two, stack return high then low, load target.
// R18: Return reads high at SP, low at SP+1 into PC, SP rises two.
// R19: Paged call stacks return, then old page at SP-3, loads new page.
// R20: Paged page is immediate; indirect form fetches target and page.
// R21: Paged return restores page, then PC from next two bytes, SP+3.
// R22: Paged call and return work whether or not memory is expanded.
// R23: Untaken branch continues at next instruction, PC unchanged.
// R24: Flags never change; loop forms always write counter back.
module branch_and_subroutine_flow_unit
	import flow_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             memReq,
	output logic             memWe,
	output logic      [15:0] memAddr,
	output logic      [7:0]  memWdata,
	input  wire logic [7:0]  memRdata,
	input  wire logic        memAck
);
	// ****************************
	// State
	// ****************************
	typedef struct packed {
		state_t      fsm;
		logic        hready;
		logic        hresp;
		logic        rdPend;
		logic [7:0]  rdOfs;
		logic        wrPend;
		logic [7:0]  wrOfs;
		logic [31:0] hrdata;
		logic [15:0] cmd;
		logic [3:0]  flags;
		logic [15:0] pc;
		logic [15:0] sp;
		logic [7:0]  page;
		logic [7:0]  newPage;
		logic [15:0] disp;
		logic [15:0] target;
		logic [15:0] dest;
		logic [7:0]  mask;
		logic [7:0]  a;
		logic [7:0]  b;
		logic [15:0] x;
		logic [15:0] y;
		logic [7:0]  hiByte;
		logic        taken;
		logic        done;
		logic        memReq;
		logic        memWe;
		logic [15:0] memAddr;
		logic [7:0]  memWdata;
	} st_t;

	localparam st_t ST_RST = '{fsm: ST_IDLE, hready: 1'b1, pc: RST_PC,
		sp: RST_SP, default: '0};

	st_t         st_ff;
	st_t         nxt_st;
	logic [15:0] cmdIn;
	logic        startFire;
	logic        condOk;
	logic        bitOk;
	logic [15:0] shortDest;
	logic [15:0] longDest;
	logic [15:0] loopDest;
	logic [15:0] loopCnt;
	logic        loopZero;
	logic [15:0] popWord;

	// ****************************
	// Functions
	// ****************************
	function automatic logic [15:0] sx8(input logic [7:0] v);
		return {{8{v[7]}}, v};
	endfunction

	function automatic logic [15:0] sx9(input logic [8:0] v);
		return {{7{v[8]}}, v};
	endfunction

	function automatic logic condHolds(input logic [3:0] cc,
		input logic [3:0] f);
		logic c;
		logic v;
		logic z;
		logic n;
		c = f[FLG_C];
		v = f[FLG_V];
		z = f[FLG_Z];
		n = f[FLG_N];
		unique case (cc)
			C_ALWAYS: return 1'b1; // R5
			C_NEVER:  return 1'b0; // R5
			C_CC:     return !c; // R6 R7
			C_CS:     return c; // R6 R7 R9
			C_EQ:     return z; // R6
			C_MI:     return n; // R6
			C_NE:     return !z; // R6
			C_PL:     return !n; // R6
			C_VC:     return !v; // R6
			C_VS:     return v; // R6
			C_HI:     return !(c | z); // R7
			C_LS:     return c | z; // R7
			C_GE:     return !(n ^ v); // R8
			C_GT:     return !(z | (n ^ v)); // R8
			C_LE:     return z | (n ^ v); // R8
			C_LT:     return n ^ v; // R8
		endcase
	endfunction

	function automatic logic [15:0] cntRead(input logic [2:0] sel,
		input st_t s);
		case (sel)
			SEL_A:   return {ZERO8, s.a};
			SEL_B:   return {ZERO8, s.b};
			SEL_D:   return {s.a, s.b};
			SEL_X:   return s.x;
			SEL_Y:   return s.y;
			default: return s.sp;
		endcase
	endfunction

	function automatic logic [31:0] rdMux(input logic [7:0] ofs,
		input st_t s);
		case (ofs)
			OFS_CMD:    return {16'h0000, s.cmd};
			OFS_STATUS: return {29'h00000000, s.done, s.taken,
				s.fsm != ST_IDLE};
			OFS_FLAGS:  return {28'h0000000, s.flags};
			OFS_PC:     return {16'h0000, s.pc};
			OFS_SP:     return {16'h0000, s.sp};
			OFS_PAGE:   return {24'h000000, s.page};
			OFS_DISP:   return {16'h0000, s.disp};
			OFS_TARGET: return {16'h0000, s.target};
			OFS_MASK:   return {24'h000000, s.mask};
			OFS_ACCD:   return {16'h0000, s.a, s.b};
			OFS_X:      return {16'h0000, s.x};
			OFS_Y:      return {16'h0000, s.y};
			OFS_NEWPG:  return {24'h000000, s.newPage};
			default:    return 32'h00000000;
		endcase
	endfunction

	// ****************************
	// Decision datapath
	// ****************************
	assign cmdIn     = hwdata[15:0];
	assign startFire = ce && st_ff.wrPend && st_ff.wrOfs == OFS_CMD &&
		st_ff.fsm == ST_IDLE;
	assign condOk    = condHolds(cmdIn[CMD_COND +: 4], st_ff.flags);
	assign shortDest = st_ff.pc + sx8(st_ff.disp[7:0]); // R1 R2 R11
	assign longDest  = st_ff.pc + st_ff.disp; // R3 R4
	assign loopDest  = st_ff.pc + sx9(st_ff.disp[8:0]); // R13
	assign bitOk     = st_ff.cmd[CMD_KIND +: 4] == K_BSET ?
		((~memRdata & st_ff.mask) == ZERO8) :
		((memRdata & st_ff.mask) == ZERO8); // R10
	assign popWord   = {st_ff.hiByte, memRdata};

	always_comb begin
		logic [15:0] cnt;
		logic        byteCnt;
		cnt = cntRead(cmdIn[CMD_SEL +: 3], st_ff);
		byteCnt = cmdIn[CMD_SEL +: 3] == SEL_A ||
			cmdIn[CMD_SEL +: 3] == SEL_B;
		unique case (cmdIn[CMD_MODE +: 2])
			LM_DEC:  loopCnt = cnt - ONE; // R14
			LM_INC:  loopCnt = cnt + ONE; // R14
			default: loopCnt = cnt; // R15
		endcase
		loopZero = byteCnt ? loopCnt[7:0] == ZERO8 :
			loopCnt == 16'h0000; // R12
	end

	// ****************************
	// Next state
	// ****************************
	always_comb begin
		nxt_st = st_ff;
		// Read data phase: one wait state, then data
		if (st_ff.rdPend) begin
			nxt_st.hrdata = rdMux(st_ff.rdOfs, st_ff);
			nxt_st.hready = 1'b1;
			nxt_st.rdPend = 1'b0;
		end
		nxt_st.wrPend = 1'b0;
		// Write data phase; registers frozen while sequencing
		if (st_ff.wrPend && st_ff.fsm == ST_IDLE) begin
			case (st_ff.wrOfs)
				OFS_FLAGS:  nxt_st.flags = hwdata[3:0];
				OFS_PC:     nxt_st.pc = hwdata[15:0];
				OFS_SP:     nxt_st.sp = hwdata[15:0];
				OFS_PAGE:   nxt_st.page = hwdata[7:0];
				OFS_DISP:   nxt_st.disp = hwdata[15:0];
				OFS_TARGET: nxt_st.target = hwdata[15:0];
				OFS_MASK:   nxt_st.mask = hwdata[7:0];
				OFS_ACCD:   {nxt_st.a, nxt_st.b} = hwdata[15:0];
				OFS_X:      nxt_st.x = hwdata[15:0];
				OFS_Y:      nxt_st.y = hwdata[15:0];
				OFS_NEWPG:  nxt_st.newPage = hwdata[7:0];
				default: ;
			endcase
		end
		// Address phase
		if (hsel && htrans[1] && hready && st_ff.hready) begin
			if (hwrite) begin
				nxt_st.wrPend = 1'b1;
				nxt_st.wrOfs = haddr[31:8] == ADDR_HI_ZERO ?
					haddr[7:0] : OFS_NONE;
			end else begin
				nxt_st.rdPend = 1'b1;
				nxt_st.hready = 1'b0;
				nxt_st.rdOfs = haddr[31:8] == ADDR_HI_ZERO ?
					haddr[7:0] : OFS_NONE;
			end
		end
		// Command start
		if (startFire) begin
			nxt_st.cmd = cmdIn;
			nxt_st.done = 1'b1;
			nxt_st.taken = 1'b0;
			case (cmdIn[CMD_KIND +: 4])
				K_SHORT: begin
					nxt_st.taken = condOk;
					if (condOk)
						nxt_st.pc = shortDest; // R1 R2 R5 R23
				end
				K_LONG: begin
					nxt_st.taken = condOk;
					if (condOk)
						nxt_st.pc = longDest; // R3 R4 R9 R23
				end
				K_BSET, K_BCLR: begin
					nxt_st.done = 1'b0;
					nxt_st.fsm = ST_BITRD;
					nxt_st.memAddr = st_ff.target; // R10
				end
				K_LOOP: begin
					case (cmdIn[CMD_SEL +: 3]) // R24
						SEL_A:   nxt_st.a = loopCnt[7:0];
						SEL_B:   nxt_st.b = loopCnt[7:0];
						SEL_D:   {nxt_st.a, nxt_st.b} = loopCnt;
						SEL_X:   nxt_st.x = loopCnt;
						SEL_Y:   nxt_st.y = loopCnt;
						default: nxt_st.sp = loopCnt;
					endcase
					nxt_st.taken = loopZero == cmdIn[CMD_ZERO]; // R14 R15
					if (loopZero == cmdIn[CMD_ZERO])
						nxt_st.pc = loopDest; // R13 R23
				end
				K_JUMP: begin
					nxt_st.taken = 1'b1;
					nxt_st.pc = st_ff.target; // R16
				end
				K_SUBREL, K_SUBABS, K_PCALL: begin
					nxt_st.done = 1'b0;
					nxt_st.dest = cmdIn[CMD_KIND +: 4] == K_SUBREL ?
						shortDest : st_ff.target;
					if (cmdIn[CMD_KIND +: 4] == K_PCALL && cmdIn[CMD_IND])
					begin
						nxt_st.fsm = ST_INDH; // R20
						nxt_st.memAddr = st_ff.target;
					end else begin
						nxt_st.fsm = ST_PUSHH; // R17
						nxt_st.memAddr = st_ff.sp - TWO;
						nxt_st.memWdata = st_ff.pc[15:8];
					end
				end
				K_RTS, K_RTC: begin
					nxt_st.done = 1'b0;
					nxt_st.fsm = cmdIn[CMD_KIND +: 4] == K_RTC ?
						ST_POPPG : ST_POPH;
					nxt_st.memAddr = st_ff.sp; // R18 R21
				end
				default: ;
			endcase
		end
		// Memory sequencing, one byte per acknowledge
		if (st_ff.memReq && memAck) begin
			unique case (st_ff.fsm)
				ST_BITRD: begin
					nxt_st.taken = bitOk;
					if (bitOk)
						nxt_st.pc = shortDest; // R10 R11
					nxt_st.fsm = ST_IDLE;
				end
				ST_INDH: begin
					nxt_st.dest[15:8] = memRdata; // R20
					nxt_st.fsm = ST_INDL;
					nxt_st.memAddr = st_ff.memAddr + ONE;
				end
				ST_INDL: begin
					nxt_st.dest[7:0] = memRdata;
					nxt_st.fsm = ST_INDPG;
					nxt_st.memAddr = st_ff.memAddr + ONE;
				end
				ST_INDPG: begin
					nxt_st.newPage = memRdata; // R20
					nxt_st.fsm = ST_PUSHH;
					nxt_st.memAddr = st_ff.sp - TWO;
					nxt_st.memWdata = st_ff.pc[15:8];
				end
				ST_PUSHH: begin
					nxt_st.fsm = ST_PUSHL; // R17
					nxt_st.memAddr = st_ff.sp - ONE;
					nxt_st.memWdata = st_ff.pc[7:0];
				end
				ST_PUSHL: begin
					if (st_ff.cmd[CMD_KIND +: 4] == K_PCALL) begin
						nxt_st.fsm = ST_PUSHP; // R19
						nxt_st.memAddr = st_ff.sp - THREE;
						nxt_st.memWdata = st_ff.page;
					end else begin
						nxt_st.sp = st_ff.sp - TWO; // R17
						nxt_st.pc = st_ff.dest;
						nxt_st.taken = 1'b1;
						nxt_st.fsm = ST_IDLE;
					end
				end
				ST_PUSHP: begin
					nxt_st.sp = st_ff.sp - THREE; // R19 R22
					nxt_st.page = st_ff.newPage;
					nxt_st.pc = st_ff.dest;
					nxt_st.taken = 1'b1;
					nxt_st.fsm = ST_IDLE;
				end
				ST_POPPG: begin
					nxt_st.page = memRdata; // R21 R22
					nxt_st.fsm = ST_POPH;
					nxt_st.memAddr = st_ff.memAddr + ONE;
				end
				ST_POPH: begin
					nxt_st.hiByte = memRdata; // R18
					nxt_st.fsm = ST_POPL;
					nxt_st.memAddr = st_ff.memAddr + ONE;
				end
				ST_POPL: begin
					nxt_st.pc = popWord; // R18 R21
					nxt_st.sp = st_ff.sp +
						(st_ff.cmd[CMD_KIND +: 4] == K_RTC ? THREE : TWO);
					nxt_st.taken = 1'b1;
					nxt_st.fsm = ST_IDLE;
				end
				default: nxt_st.fsm = ST_IDLE;
			endcase
			if (nxt_st.fsm == ST_IDLE)
				nxt_st.done = 1'b1;
		end
		nxt_st.memReq = nxt_st.fsm != ST_IDLE;
		nxt_st.memWe = nxt_st.fsm == ST_PUSHH || nxt_st.fsm == ST_PUSHL ||
			nxt_st.fsm == ST_PUSHP;
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			st_ff <= ST_RST;
		else if (ce)
			st_ff <= nxt_st;
	end

	assign hrdata    = st_ff.hrdata;
	assign hreadyout = st_ff.hready;
	assign hresp     = st_ff.hresp;
	assign memReq    = st_ff.memReq;
	assign memWe     = st_ff.memWe;
	assign memAddr   = st_ff.memAddr;
	assign memWdata  = st_ff.memWdata;

	// ****************************
	// Checks
	// ****************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence pushHigh;
		memReq && memWe && memAddr == st_ff.sp - TWO &&
			memWdata == st_ff.pc[15:8];
	endsequence

	sequence pushLow;
		memReq && memWe && memAddr == st_ff.sp - ONE &&
			memWdata == st_ff.pc[7:0];
	endsequence

	shortTaken_a: assert property ( // R1
		startFire && cmdIn[CMD_KIND +: 4] == K_SHORT && condOk
		|=> st_ff.pc == $past(shortDest) && st_ff.taken)
		else $error("short branch target wrong");
	untakenKeep_a: assert property ( // R23
		startFire && cmdIn[CMD_KIND +: 4] == K_LONG && !condOk
		|=> $stable(st_ff.pc) && !st_ff.taken)
		else $error("untaken branch moved pc");
	longTaken_a: assert property ( // R3
		startFire && cmdIn[CMD_KIND +: 4] == K_LONG && condOk
		|=> st_ff.pc == $past(longDest))
		else $error("long branch target wrong");
	neverBranch_a: assert property ( // R5
		startFire && cmdIn[CMD_COND +: 4] == C_NEVER &&
		cmdIn[CMD_KIND +: 4] == K_SHORT |=> !st_ff.taken && st_ff.done)
		else $error("branch never was taken");
	flagsKeep_a: assert property ( // R24
		st_ff.fsm != ST_IDLE || startFire |=> $stable(st_ff.flags))
		else $error("flags changed by flow");
	loopDec_a: assert property ( // R14
		startFire && cmdIn[CMD_KIND +: 4] == K_LOOP &&
		cmdIn[CMD_SEL +: 3] == SEL_X && cmdIn[CMD_MODE +: 2] == LM_DEC
		|=> st_ff.x == $past(st_ff.x) - ONE)
		else $error("loop counter not decremented");
	callPush_a: assert property ( // R17
		startFire && cmdIn[CMD_KIND +: 4] == K_SUBABS
		|=> pushHigh ##[1:20] pushLow)
		else $error("call stacking order wrong");
	retPop_a: assert property ( // R18
		st_ff.fsm == ST_POPL && memAck && st_ff.cmd[CMD_KIND +: 4] == K_RTS
		|=> st_ff.pc == $past(popWord) && st_ff.sp == $past(st_ff.sp) + TWO)
		else $error("return reload wrong");
	pagedPush_a: assert property ( // R19
		st_ff.fsm == ST_PUSHP && memAck
		|=> st_ff.page == $past(st_ff.newPage) &&
			st_ff.sp == $past(st_ff.sp) - THREE)
		else $error("paged call stacking wrong");
	bitBranch_a: assert property ( // R10
		st_ff.fsm == ST_BITRD && memAck && bitOk
		|=> st_ff.pc == $past(shortDest) && st_ff.fsm == ST_IDLE)
		else $error("bit branch wrong");
endmodule

/* File: rtl/flow_pkg.sv */
package flow_pkg;
	// ****************************
	// Sequencer states
	// ****************************
	typedef enum logic [10:0] {
		ST_IDLE  = 11'h001,
		ST_BITRD = 11'h002,
		ST_INDH  = 11'h004,
		ST_INDL  = 11'h008,
		ST_INDPG = 11'h010,
		ST_PUSHH = 11'h020,
		ST_PUSHL = 11'h040,
		ST_PUSHP = 11'h080,
		ST_POPPG = 11'h100,
		ST_POPH  = 11'h200,
		ST_POPL  = 11'h400
	} state_t;
	// ****************************
	// Command kinds and conditions
	// ****************************
	localparam logic [3:0] K_SHORT = 4'h0, K_LONG = 4'h1, K_BSET = 4'h2,
		K_BCLR = 4'h3, K_LOOP = 4'h4, K_JUMP = 4'h5, K_SUBREL = 4'h6,
		K_SUBABS = 4'h7, K_PCALL = 4'h8, K_RTS = 4'h9, K_RTC = 4'ha;
	localparam logic [3:0] C_ALWAYS = 4'h0, C_NEVER = 4'h1, C_CC = 4'h2,
		C_CS = 4'h3, C_EQ = 4'h4, C_MI = 4'h5, C_NE = 4'h6, C_PL = 4'h7,
		C_VC = 4'h8, C_VS = 4'h9, C_HI = 4'ha, C_LS = 4'hb, C_GE = 4'hc,
		C_GT = 4'hd, C_LE = 4'he, C_LT = 4'hf;
	localparam logic [2:0] SEL_A = 3'h0, SEL_B = 3'h1, SEL_D = 3'h2,
		SEL_X = 3'h3, SEL_Y = 3'h4, SEL_SP = 3'h5;
	localparam logic [1:0] LM_DEC = 2'h0, LM_INC = 2'h1, LM_TEST = 2'h2;
	// ****************************
	// Field positions
	// ****************************
	localparam int CMD_KIND = 0, CMD_COND = 4, CMD_SEL = 8, CMD_MODE = 11;
	localparam int CMD_ZERO = 13, CMD_IND = 14;
	localparam int FLG_C = 0, FLG_V = 1, FLG_Z = 2, FLG_N = 3;
	localparam int STAT_BUSY = 0, STAT_TAKEN = 1, STAT_DONE = 2;
	// ****************************
	// Register offsets
	// ****************************
	localparam logic [7:0] OFS_CMD = 8'h00, OFS_STATUS = 8'h04,
		OFS_FLAGS = 8'h08, OFS_PC = 8'h0c, OFS_SP = 8'h10,
		OFS_PAGE = 8'h14, OFS_DISP = 8'h18, OFS_TARGET = 8'h1c,
		OFS_MASK = 8'h20, OFS_ACCD = 8'h24, OFS_X = 8'h28, OFS_Y = 8'h2c,
		OFS_NEWPG = 8'h30, OFS_NONE = 8'hfc;
	localparam logic [23:0] ADDR_HI_ZERO = 24'h000000;
	// ****************************
	// Constants and reset values
	// ****************************
	localparam logic [15:0] ONE = 16'h0001, TWO = 16'h0002;
	localparam logic [15:0] THREE = 16'h0003, RST_SP = 16'h0000;
	localparam logic [15:0] RST_PC = 16'h0000;
	localparam logic [7:0] ZERO8 = 8'h00;
endpackage

/* File: test/flow_mem_model.sv */
`timescale 1ns/10ps
module flow_mem_model (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        memReq,
	input  wire logic        memWe,
	input  wire logic [15:0] memAddr,
	input  wire logic [7:0]  memWdata,
	input  wire logic [1:0]  memWait,
	output logic      [7:0]  memRdata,
	output logic             memAck
);
	logic [7:0] mem [0:65535];
	logic [1:0] waitCnt;

	initial begin
		memRdata = 8'h00;
		memAck = 1'b0;
		waitCnt = 2'h0;
	end

	// Read byte only valid on ack; inverted on every cycle otherwise
	always @(posedge clk) begin
		memAck <= 1'b0;
		memRdata <= ~memRdata;
		if (!rst_b) begin
			waitCnt <= 2'h0;
		end else if (memReq && !memAck) begin
			if (waitCnt == memWait) begin
				memAck <= 1'b1;
				waitCnt <= 2'h0;
				if (memWe) begin
					mem[memAddr] <= memWdata;
				end else begin
					memRdata <= mem[memAddr];
				end
			end else begin
				waitCnt <= waitCnt + 2'h1;
			end
		end
	end
endmodule

/* File: test/branch_and_subroutine_flow_unit_tb_top.sv */
`timescale 1ns/10ps
module branch_and_subroutine_flow_unit_tb_top;
	import flow_pkg::*;
	typedef struct packed {
		logic [15:0] cmd;
		logic [3:0]  flg;
		logic [15:0] disp;
		logic [15:0] pc;
	} row_t;
	// ****************************
	// Branch decision table, PC starts at 1000
	// ****************************
	localparam row_t ROWS [21] = '{
		'{16'h0000, 4'h0, 16'h0080, 16'h0f80}, '{16'h0010, 4'hf, 16'h007f, 16'h1000},
		'{16'h0020, 4'h0, 16'h007f, 16'h107f}, '{16'h0030, 4'h0, 16'h0010, 16'h1000},
		'{16'h0040, 4'h4, 16'h0010, 16'h1010}, '{16'h0050, 4'h0, 16'h0010, 16'h1000},
		'{16'h0060, 4'h0, 16'h0010, 16'h1010}, '{16'h0070, 4'h8, 16'h0010, 16'h1000},
		'{16'h0080, 4'h2, 16'h0010, 16'h1000}, '{16'h0090, 4'h2, 16'h0010, 16'h1010},
		'{16'h00a0, 4'h4, 16'h0010, 16'h1000}, '{16'h00b0, 4'h1, 16'h0010, 16'h1010},
		'{16'h00c0, 4'ha, 16'h0010, 16'h1010}, '{16'h00d0, 4'hc, 16'h0010, 16'h1000},
		'{16'h00e0, 4'h8, 16'h0010, 16'h1010}, '{16'h00f0, 4'h8, 16'h0010, 16'h1010},
		'{16'h0001, 4'h0, 16'h8000, 16'h9000}, '{16'h0011, 4'h0, 16'h7fff, 16'h1000},
		'{16'h0031, 4'h1, 16'h7fff, 16'h8fff}, '{16'h0031, 4'h4, 16'h0100, 16'h1000},
		'{16'h0005, 4'h0, 16'hbeef, 16'hbeef}
	};

	logic        clk;
	logic        rst_b;
	logic        ce;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        memReq;
	logic        memWe;
	logic [15:0] memAddr;
	logic [7:0]  memWdata;
	logic [7:0]  memRdata;
	logic        memAck;
	logic [1:0]  memWait;
	int          errCount;
	int          totalChecks;

	branch_and_subroutine_flow_unit i_dut (
		.clk(clk), .rst_b(rst_b), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
		.memWdata(memWdata), .memRdata(memRdata), .memAck(memAck)
	);

	flow_mem_model i_mem (
		.clk(clk), .rst_b(rst_b), .memReq(memReq), .memWe(memWe),
		.memAddr(memAddr), .memWdata(memWdata), .memWait(memWait),
		.memRdata(memRdata), .memAck(memAck)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ****************************
	// Bus and check tasks
	// ****************************
	task automatic close_out;
		$display("checks %0d mismatches %0d", totalChecks, errCount);
		if (errCount == 0 && totalChecks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] expv,
		input logic [31:0] got);
		totalChecks++;
		if (got !== expv) begin
			errCount++;
			$display("ERROR %s expected %h seen %h", name, expv, got);
		end
	endtask

	task automatic xfer(input logic [7:0] ofs, input logic wrt,
		input logic [15:0] val, output logic [31:0] rdv);
		logic rdy;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {ADDR_HI_ZERO, ofs};
		hwrite <= wrt;
		// Settled values seen mid-cycle equal what the next edge samples
		do begin
			@(negedge clk);
			rdy = hreadyout;
			@(posedge clk);
		end while (rdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {16'h0000, val};
		do begin
			@(negedge clk);
			rdy = hreadyout;
			rdv = hrdata;
			@(posedge clk);
		end while (rdy !== 1'b1);
	endtask

	task automatic wr(input logic [7:0] ofs, input logic [15:0] val);
		logic [31:0] unused;
		xfer(ofs, 1'b1, val, unused);
	endtask

	task automatic chkReg(input string name, input logic [7:0] ofs,
		input logic [15:0] expv);
		logic [31:0] v;
		xfer(ofs, 1'b0, 16'h0000, v);
		chk(name, {16'h0000, expv}, v);
	endtask

	task automatic waitDone;
		logic [31:0] s;
		int n;
		n = 0;
		do begin
			xfer(OFS_STATUS, 1'b0, 16'h0000, s);
			n++;
		end while (s[STAT_DONE] !== 1'b1 && n < 40);
		chk("done", 32'h1, {31'h0, s[STAT_DONE]});
	endtask

	task automatic go(input logic [15:0] cmd);
		wr(OFS_CMD, cmd);
		waitDone();
	endtask

	task automatic doLoop(input logic [15:0] cmd, input logic [7:0] ofs,
		input logic [15:0] init, input logic [15:0] disp,
		input logic [15:0] expCnt, input logic [15:0] expPc);
		wr(ofs, init);
		wr(OFS_DISP, disp);
		wr(OFS_PC, 16'h1000);
		go(cmd);
		chkReg("counter", ofs, expCnt);
		chkReg("pc", OFS_PC, expPc);
	endtask

	task automatic doBit(input logic [15:0] cmd, input logic [15:0] mask,
		input logic [15:0] disp, input logic [15:0] expPc);
		wr(OFS_MASK, mask);
		wr(OFS_DISP, disp);
		wr(OFS_TARGET, 16'h2000);
		wr(OFS_PC, 16'h1000);
		go(cmd);
		chkReg("pc", OFS_PC, expPc);
	endtask

	function automatic logic [31:0] memAt(input logic [15:0] a);
		return {24'h000000, i_mem.mem[a]};
	endfunction

	initial begin
		repeat (30000) @(posedge clk);
		errCount++;
		close_out();
	end

	// ****************************
	// Main sequence
	// ****************************
	initial begin
		errCount = 0;
		totalChecks = 0;
		rst_b = 1'b0;
		ce = 1'b1;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		memWait = 2'h0;
		repeat (16) @(posedge clk);
		chk("memReq", 32'h0, {31'h0, memReq});
		chk("hreadyout", 32'h1, {31'h0, hreadyout});
		rst_b <= 1'b1;
		chkReg("pc", OFS_PC, 16'h0000);
		chkReg("sp", OFS_SP, 16'h0000);
		chkReg("status", OFS_STATUS, 16'h0000);
		wr(OFS_NONE, 16'hffff);
		chkReg("unmapped", OFS_NONE, 16'h0000);
		chk("hresp", 32'h0, {31'h0, hresp});
		for (int i = 0; i < 21; i++) begin
			wr(OFS_FLAGS, {12'h000, ROWS[i].flg});
			wr(OFS_DISP, ROWS[i].disp);
			wr(OFS_TARGET, ROWS[i].disp);
			wr(OFS_PC, 16'h1000);
			go(ROWS[i].cmd);
			chkReg("pc", OFS_PC, ROWS[i].pc);
			chkReg("flags", OFS_FLAGS, {12'h000, ROWS[i].flg});
		end
		doLoop(16'h2304, OFS_X, 16'h0001, 16'h0100, 16'h0000, 16'h0f00);
		doLoop(16'h2804, OFS_ACCD, 16'hff00, 16'h00ff, 16'h0000, 16'h10ff);
		doLoop(16'h1404, OFS_Y, 16'h0005, 16'h0010, 16'h0005, 16'h1010);
		doLoop(16'h0504, OFS_SP, 16'h0001, 16'h0010, 16'h0000, 16'h1000);
		doLoop(16'h2104, OFS_ACCD, 16'h0102, 16'h0010, 16'h0101, 16'h1000);
		doLoop(16'h3304, OFS_X, 16'h0000, 16'h01fe, 16'h0000, 16'h0ffe);
		i_mem.mem[16'h2000] = 8'ha5;
		doBit(16'h0002, 16'h0021, 16'h0010, 16'h1010);
		doBit(16'h0003, 16'h005a, 16'h00f0, 16'h0ff0);
		doBit(16'h0002, 16'h0003, 16'h0010, 16'h1000);
		doBit(16'h0003, 16'h0021, 16'h0080, 16'h1000);
		memWait <= 2'h2;
		wr(OFS_SP, 16'h3000);
		wr(OFS_PC, 16'h1000);
		wr(OFS_DISP, 16'h0020);
		go(16'h0006);
		chk("stack hi", 32'h10, memAt(16'h2ffe));
		chk("stack lo", 32'h00, memAt(16'h2fff));
		chkReg("sp", OFS_SP, 16'h2ffe);
		chkReg("pc", OFS_PC, 16'h1020);
		go(16'h0009);
		chkReg("pc", OFS_PC, 16'h1000);
		chkReg("sp", OFS_SP, 16'h3000);
		memWait <= 2'h0;
		wr(OFS_PAGE, 16'h0005);
		wr(OFS_NEWPG, 16'h003c);
		wr(OFS_TARGET, 16'h4000);
		wr(OFS_PC, 16'h1234);
		go(16'h0008);
		chk("page slot", 32'h05, memAt(16'h2ffd));
		chk("stack hi", 32'h12, memAt(16'h2ffe));
		chk("stack lo", 32'h34, memAt(16'h2fff));
		chkReg("sp", OFS_SP, 16'h2ffd);
		chkReg("page", OFS_PAGE, 16'h003c);
		chkReg("pc", OFS_PC, 16'h4000);
		go(16'h000a);
		chkReg("page", OFS_PAGE, 16'h0005);
		chkReg("pc", OFS_PC, 16'h1234);
		chkReg("sp", OFS_SP, 16'h3000);
		i_mem.mem[16'h2100] = 8'h55;
		i_mem.mem[16'h2101] = 8'h66;
		i_mem.mem[16'h2102] = 8'h07;
		wr(OFS_TARGET, 16'h2100);
		go(16'h4008);
		chkReg("pc", OFS_PC, 16'h5566);
		chkReg("page", OFS_PAGE, 16'h0007);
		memWait <= 2'h3;
		wr(OFS_SP, 16'h3000);
		wr(OFS_TARGET, 16'h6000);
		wr(OFS_PC, 16'h0100);
		wr(OFS_CMD, 16'h0007);
		wr(OFS_PC, 16'hffff);
		waitDone();
		chkReg("pc", OFS_PC, 16'h6000);
		chk("stack hi", 32'h01, memAt(16'h2ffe));
		chkReg("sp", OFS_SP, 16'h2ffe);
		wr(OFS_CMD, 16'h0009);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		chk("memReq", 32'h0, {31'h0, memReq});
		chkReg("pc", OFS_PC, 16'h0000);
		chkReg("sp", OFS_SP, 16'h0000);
		close_out();
	end
endmodule
